// ===== hdl/pdis_pkg.sv
// Constants and register map of the PD port interrupt and live status group
//------------------------------------------------------------------------------
// Functional notes
// R01 - Overcurrent or heat event sets event bit 7
// R02 - Role search stop on attach sets bit 6
// R03 - Soft reset retries all failed sets bit 5
// R04 - Ordinary packet retries exhausted sets bit 4
// R05 - Hard reset sent successfully sets bit 3
// R06 - Transmitted packet acknowledged sets bit 2
// R07 - Incoming soft reset packet sets bit 1
// R08 - Incoming hard reset ordered set sets bit 0
// R09 - Event registers reset zero, clear on read
// R10 - Automatic acknowledge sent sets ack bit 0
// R11 - Live bit 7 shows bus power present
// R12 - Live bit 6: three CC edges, quiet clears
// R13 - Live bit 5 shows CC above reference
// R14 - Live bit 4 checksum good until next start
// R15 - Live bit 3 alerts on any full FIFO
// R16 - Live bit 2 shows attach wake when enabled
// R17 - Live bits 1:0 encode CC current level
// R18 - Level valid only when measuring and powered
// R19 - Software samples level with CC line quiet
// R20 - Live register read only, resets to zero
// R21 - Flags stay latched; set beats read clear
// R22 - Interrupt pin low while any flag set
//------------------------------------------------------------------------------
package pdis_pkg;

   //---------------------------------------------------------------------------
   // Register offsets and reset values
   //---------------------------------------------------------------------------
   localparam logic [7:0] ADDR_EVENT = 8'h3E; // pd_event_flags
   localparam logic [7:0] ADDR_ACK = 8'h3F; // ack_sent_flags
   localparam logic [7:0] ADDR_LIVE = 8'h40; // live_port_state
   localparam logic [7:0] RST_EVENT = 8'h00;
   localparam logic [7:0] RST_ACK = 8'h00;
   localparam logic [7:0] RST_LIVE = 8'h00;

   //---------------------------------------------------------------------------
   // Field positions
   //---------------------------------------------------------------------------
   localparam int EV_HEAT = 7; // fault_overcurrent_heat_irq
   localparam int EV_ROLE = 6; // role_search_finished_irq
   localparam int EV_SOFTFAIL = 5; // soft_reset_gave_up_irq
   localparam int EV_RESEND = 4; // resend_exhausted_irq
   localparam int EV_HARDOUT = 3; // hard_reset_out_irq
   localparam int EV_ACKED = 2; // packet_acked_irq
   localparam int EV_SOFTIN = 1; // soft_reset_in_irq
   localparam int EV_HARDIN = 0; // hard_reset_in_irq
   localparam int AK_SENT = 0; // auto_ack_sent_irq
   localparam int LV_POWER = 7; // bus_power_present
   localparam int LV_ACTIVE = 6; // CC line activity
   localparam int LV_COMP = 5; // comparator result
   localparam int LV_CRC = 4; // rx_checksum_good
   localparam int LV_ALERT = 3; // FIFO alert
   localparam int LV_WAKE = 2; // attach wake
   localparam int LV_LEVEL = 0; // cc_current_level, two bits
   localparam int PWR_MEASURE = 2; // measure block power bit

   //---------------------------------------------------------------------------
   // Timing
   //---------------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACT_QUIET_NS = 10000; // quiet time that ends activity
   localparam logic [15:0] ACT_QUIET_CYC = 16'(ACT_QUIET_NS / CLK_PERIOD_NS);
   localparam logic [1:0] ACT_MIN_EDGES = 2'h3; // edges before activity

   // Activity detector states, one-hot
   typedef enum logic [2:0] {
      ACT_IDLE = 3'b001,
      ACT_SEEN = 3'b010,
      ACT_BUSY = 3'b100
   } pdis_act_t;

endpackage : pdis_pkg

// ===== hdl/pdis_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module pdis_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   //---------------------------------------------------------------------------
   // Synchroniser chain
   //---------------------------------------------------------------------------
   // First stage feeds only the second stage; nothing else may look at it
   logic [WIDTH-1:0] stage1_reg;

   // Both stages reset to zero so status reads zero out of reset
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage1_reg <= '0;
         sync_o <= '0;
      end else begin
         stage1_reg <= async_i;
         sync_o <= stage1_reg;
      end
   end

endmodule : pdis_sync

// ===== hdl/pdis_top.sv
// PD port event flags, acknowledge flags and live port state registers
`timescale 1ns/1ns
module pdis_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Host register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Interrupt to host, active low
   output logic int_n_o,
   // Asynchronous analog levels
   input wire logic vconn1_overcurrent_event_i,
   input wire logic vconn2_overcurrent_event_i,
   input wire logic over_temp_i,
   input wire logic bus_power_present_i,
   input wire logic cc_line_i,
   input wire logic cc_above_ref_i,
   input wire logic wake_detect_i,
   input wire logic cc_over_200_i,
   input wire logic cc_over_660_i,
   input wire logic cc_over_1230_i,
   // Configuration from same-clock register logic
   input wire logic wake_enable_i,
   input wire logic [3:0] block_power_bits_i,
   input wire logic measure_first_cc_i,
   input wire logic measure_second_cc_i,
   // Single-cycle events from same-clock protocol logic
   input wire logic role_search_done_i,
   input wire logic soft_reset_gave_up_i,
   input wire logic resend_exhausted_i,
   input wire logic hard_reset_out_i,
   input wire logic packet_acked_i,
   input wire logic soft_reset_in_i,
   input wire logic hard_reset_in_i,
   input wire logic auto_ack_sent_i,
   // Receive checksum result from same-clock receiver
   input wire logic rx_sop_i,
   input wire logic rx_sop_enabled_i,
   input wire logic rx_crc_done_i,
   input wire logic rx_crc_ok_i,
   // FIFO levels from same-clock FIFO logic
   input wire logic tx_fifo_full_i,
   input wire logic rx_fifo_full_i
);
   import pdis_pkg::*;

   //---------------------------------------------------------------------------
   // Functions
   //---------------------------------------------------------------------------
   // Address match for a read strobe
   function automatic logic read_hit(input logic rd, input logic [7:0] addr,
                                     input logic [7:0] target);
      read_hit = rd && (addr == target);
   endfunction : read_hit

   // Thermometer code from the three CC comparators to a two-bit level
   function automatic logic [1:0] level_encode(input logic o200, input logic o660,
                                               input logic o1230);
      if (o1230) begin
         level_encode = 2'h3;
      end else if (o660) begin
         level_encode = 2'h2;
      end else if (o200) begin
         level_encode = 2'h1;
      end else begin
         level_encode = 2'h0;
      end
   endfunction : level_encode

   //---------------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------------
   logic [9:0] async_bus; // Raw analog levels gathered for syncing
   logic [9:0] sync_bus; // Same levels after two flops
   logic ocp1_s; // VCONN switch 1 over-current
   logic ocp2_s; // VCONN switch 2 over-current
   logic temp_s; // Over-temperature
   logic vbus_s; // Bus power above threshold
   logic cc_s; // Active CC line data
   logic comp_s; // CC above reference level
   logic wake_s; // Attach voltage seen
   logic l200_s; // CC above 200 mV
   logic l660_s; // CC above 660 mV
   logic l1230_s; // CC above 1.23 V
   logic heat_prev_reg; // Previous fault level for edge detect
   logic heat_rise; // Fault newly raised
   logic [7:0] event_reg; // pd_event_flags
   logic [7:0] event_next;
   logic [7:0] event_set; // Hardware set terms
   logic [7:0] ack_reg; // ack_sent_flags
   logic [7:0] ack_next;
   logic [7:0] live_reg; // live_port_state
   logic [7:0] live_next;
   logic rd_event; // Read of event flags
   logic rd_ack; // Read of acknowledge flags
   logic rd_live; // Read of live state
   logic crc_good_reg; // Checksum result of last packet
   logic crc_good_next;
   logic meas_valid; // Level measurement meaningful
   logic cc_prev_reg; // Previous CC data for edges
   logic cc_edge; // CC transition seen
   pdis_act_t act_state_reg; // Activity detector state
   logic [1:0] edge_cnt_reg; // Edges seen since idle
   logic [15:0] quiet_cnt_reg; // Cycles since the last edge
   logic [7:0] rdata_reg; // Read data holding flop
   logic rvalid_reg; // Read answer strobe
   logic int_n_reg; // Interrupt pin flop

   //---------------------------------------------------------------------------
   // Input synchronisation
   //---------------------------------------------------------------------------
   // Analog comparators are not clocked, so every level passes two flops
   assign async_bus = {vconn1_overcurrent_event_i, vconn2_overcurrent_event_i,
                       over_temp_i, bus_power_present_i, cc_line_i,
                       cc_above_ref_i, wake_detect_i, cc_over_200_i,
                       cc_over_660_i, cc_over_1230_i};

   pdis_sync #(
      .WIDTH(10)
   ) u_sync (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .async_i(async_bus),
      .sync_o(sync_bus)
   );

   assign {ocp1_s, ocp2_s, temp_s, vbus_s, cc_s, comp_s, wake_s, l200_s,
           l660_s, l1230_s} = sync_bus;

   //---------------------------------------------------------------------------
   // Fault edge detection
   //---------------------------------------------------------------------------
   // A fault that stays up would otherwise reset the flag after every read
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         heat_prev_reg <= 1'b0;
      end else begin
         heat_prev_reg <= ocp1_s | ocp2_s | temp_s;
      end
   end

   assign heat_rise = (ocp1_s | ocp2_s | temp_s) & ~heat_prev_reg; // R01

   //---------------------------------------------------------------------------
   // Register port decode
   //---------------------------------------------------------------------------
   // Writes are accepted and dropped: all three registers are RC or RO
   assign rd_event = read_hit(reg_rd_i, reg_addr_i, ADDR_EVENT);
   assign rd_ack = read_hit(reg_rd_i, reg_addr_i, ADDR_ACK);
   assign rd_live = read_hit(reg_rd_i, reg_addr_i, ADDR_LIVE);

   //---------------------------------------------------------------------------
   // Event flags
   //---------------------------------------------------------------------------
   // Set terms, one per bit position
   always_comb begin
      event_set = 8'h00;
      event_set[EV_HEAT] = heat_rise; // R01
      event_set[EV_ROLE] = role_search_done_i; // R02
      event_set[EV_SOFTFAIL] = soft_reset_gave_up_i; // R03
      event_set[EV_RESEND] = resend_exhausted_i; // R04
      event_set[EV_HARDOUT] = hard_reset_out_i; // R05
      event_set[EV_ACKED] = packet_acked_i; // R06
      event_set[EV_SOFTIN] = soft_reset_in_i; // R07
      event_set[EV_HARDIN] = hard_reset_in_i; // R08
   end

   // Read clears, but an event in the read cycle survives for the next read
   assign event_next = (event_reg & ~{8{rd_event}}) | event_set; // R09 R21

   // Only bit 0 of the acknowledge register exists; the rest read zero
   always_comb begin
      ack_next = ack_reg & ~{8{rd_ack}}; // R09 R21
      ack_next[AK_SENT] = ack_next[AK_SENT] | auto_ack_sent_i; // R10
   end

   // Flag storage
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         event_reg <= RST_EVENT; // R09
         ack_reg <= RST_ACK; // R09
      end else begin
         event_reg <= event_next;
         ack_reg <= ack_next;
      end
   end

   //---------------------------------------------------------------------------
   // Checksum status
   //---------------------------------------------------------------------------
   // Cleared at each packet start, then loaded when the check completes
   always_comb begin
      crc_good_next = crc_good_reg;
      if (rx_crc_done_i && rx_sop_enabled_i) begin
         crc_good_next = rx_crc_ok_i; // R14
      end else if (rx_sop_i) begin
         crc_good_next = 1'b0; // R14
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         crc_good_reg <= 1'b0;
      end else begin
         crc_good_reg <= crc_good_next;
      end
   end

   //---------------------------------------------------------------------------
   // CC activity detector
   //---------------------------------------------------------------------------
   // Edge seen on the synchronised CC data
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cc_prev_reg <= 1'b0;
      end else begin
         cc_prev_reg <= cc_s;
      end
   end

   assign cc_edge = cc_s ^ cc_prev_reg;

   // Needs several edges so a single glitch does not look like signalling
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_state_reg <= ACT_IDLE;
         edge_cnt_reg <= 2'h0;
         quiet_cnt_reg <= 16'h0000;
      end else if (cc_edge) begin
         quiet_cnt_reg <= 16'h0000;
         case (act_state_reg)
            ACT_IDLE: begin
               edge_cnt_reg <= 2'h1;
               act_state_reg <= ACT_SEEN;
            end
            ACT_SEEN: begin
               edge_cnt_reg <= edge_cnt_reg + 2'h1;
               if (edge_cnt_reg == ACT_MIN_EDGES - 2'h1) begin
                  act_state_reg <= ACT_BUSY; // R12
               end
            end
            ACT_BUSY: begin
               edge_cnt_reg <= edge_cnt_reg;
            end
            default: begin
               act_state_reg <= ACT_IDLE;
               edge_cnt_reg <= 2'h0;
            end
         endcase
      end else if (quiet_cnt_reg >= ACT_QUIET_CYC - 16'h0001) begin
         // Quiet too long: activity over, start counting afresh
         act_state_reg <= ACT_IDLE; // R12
         edge_cnt_reg <= 2'h0;
      end else begin
         quiet_cnt_reg <= quiet_cnt_reg + 16'h0001;
      end
   end

   //---------------------------------------------------------------------------
   // Live port state
   //---------------------------------------------------------------------------
   // Level only means something while the measure block runs on a CC pin
   assign meas_valid = block_power_bits_i[PWR_MEASURE] &
                       (measure_first_cc_i | measure_second_cc_i); // R18

   // Snapshot of live levels; software should read level while CC is quiet
   always_comb begin
      live_next = 8'h00;
      live_next[LV_POWER] = vbus_s; // R11
      live_next[LV_ACTIVE] = (act_state_reg == ACT_BUSY); // R12
      live_next[LV_COMP] = comp_s; // R13
      live_next[LV_CRC] = crc_good_next; // R14
      live_next[LV_ALERT] = tx_fifo_full_i | rx_fifo_full_i; // R15
      live_next[LV_WAKE] = wake_enable_i & wake_s; // R16
      if (meas_valid) begin
         live_next[LV_LEVEL +: 2] = level_encode(l200_s, l660_s, l1230_s); // R17 R18
      end
   end

   // Read-only: nothing on the register port reaches this flop
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         live_reg <= RST_LIVE; // R20
      end else begin
         live_reg <= live_next;
      end
   end

   //---------------------------------------------------------------------------
   // Read data path
   //---------------------------------------------------------------------------
   // Answer one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_rd_i;
         if (rd_event) begin
            rdata_reg <= event_reg; // R09
         end else if (rd_ack) begin
            rdata_reg <= ack_reg; // R09
         end else if (rd_live) begin
            rdata_reg <= live_reg; // R20
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign reg_rvalid_o = rvalid_reg;

   //---------------------------------------------------------------------------
   // Interrupt output
   //---------------------------------------------------------------------------
   // Built from next values so the pin tracks the flags with no extra lag
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_n_reg <= 1'b1;
      end else begin
         int_n_reg <= ~(|event_next | |ack_next); // R22
      end
   end

   assign int_n_o = int_n_reg;

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   AST_HARD_IN_SETS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R08
      hard_reset_in_i |=> event_reg[EV_HARDIN])
      else $error("hard reset in did not set its flag");

   AST_ACKED_SETS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R06
      packet_acked_i |=> event_reg[EV_ACKED] && !int_n_o)
      else $error("acknowledged packet did not raise flag and pin");

   AST_HEAT_SETS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R01
      $rose(ocp1_s | ocp2_s | temp_s) |=> event_reg[EV_HEAT])
      else $error("overcurrent did not set fault flag");

   AST_READ_RETURNS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R09
      rd_event |=> reg_rvalid_o && reg_rdata_o == $past(event_reg))
      else $error("event read returned wrong data");

   AST_READ_CLEARS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R09
      rd_event && event_set == 8'h00 |=> event_reg == 8'h00)
      else $error("event read did not clear flags");

   AST_SET_WINS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R21
      rd_event && resend_exhausted_i |=> event_reg[EV_RESEND] ##1 event_reg[EV_RESEND] || $past(rd_event))
      else $error("event during read was lost");

   AST_FLAG_HOLDS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R21
      event_reg[EV_ROLE] && !rd_event |=> event_reg[EV_ROLE])
      else $error("flag dropped without a read");

   AST_AUTO_ACK: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R10
      auto_ack_sent_i |=> ack_reg == 8'h01)
      else $error("auto acknowledge flag wrong");

   AST_PIN_FOLLOWS: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R22
      int_n_o == ((event_reg == 8'h00) && (ack_reg == 8'h00)))
      else $error("interrupt pin disagrees with flags");

   AST_ALERT: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R15
      (tx_fifo_full_i || rx_fifo_full_i) |=> live_reg[LV_ALERT])
      else $error("full FIFO did not raise alert");

   AST_CRC_CLEAR: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R14
      rx_sop_i && !rx_crc_done_i |=> !live_reg[LV_CRC])
      else $error("checksum status not cleared at packet start");

   AST_LEVEL_IDLE: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R18
      !meas_valid |=> live_reg[1:0] == 2'h0)
      else $error("level shown while measurement is off");

   AST_WAKE_OFF: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R16
      !wake_enable_i |=> !live_reg[LV_WAKE])
      else $error("wake shown while disabled");

endmodule : pdis_top

// ===== bench/pdis_partner.sv
// Port partner model that sends short bursts of transitions on the CC line
`timescale 1ns/1ns
module pdis_partner (
   input wire logic mclk_i,
   input wire logic go_i,
   input wire logic [3:0] edges_i,
   output logic cc_o
);
   logic [3:0] left_reg = 4'h0; // Transitions still to send
   logic [1:0] gap_reg = 2'h0; // Spacing between transitions
   initial cc_o = 1'b0;
   //------------------------------------------------------------
   // Burst generator
   //------------------------------------------------------------
   // The line stands still between bursts, as an idle partner leaves it
   always @(posedge mclk_i) begin
      if (go_i) begin
         left_reg <= edges_i;
      end else if (left_reg != 4'h0) begin
         gap_reg <= gap_reg + 2'h1;
         // One transition every four cycles, slow enough for the synchroniser
         if (gap_reg == 2'h3) begin
            cc_o <= ~cc_o;
            left_reg <= left_reg - 4'h1;
         end
      end
   end
endmodule : pdis_partner

// ===== bench/pdis_top_test.sv
// Self-checking bench for the PD event, acknowledge and live state registers
`timescale 1ns/1ns
module pdis_top_test;
   import pdis_pkg::*;
   //------------------------------------------------------------
   // Signals
   //------------------------------------------------------------
   logic mclk_i = 1'b0, resetn_i = 1'b0, reg_rd_i = 1'b0, reg_wr_i = 1'b0, go = 1'b0;
   logic reg_rvalid_o, int_n_o, cc_line_i, rx_sop_enabled_i = 1'b0, rx_crc_ok_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [3:0] block_power_bits_i = 4'h0, nedge = 4'h0;
   logic measure_first_cc_i = 1'b0, measure_second_cc_i = 1'b0, vconn1_overcurrent_event_i, vconn2_overcurrent_event_i;
   logic over_temp_i, bus_power_present_i, cc_above_ref_i, wake_detect_i, wake_enable_i, tx_fifo_full_i, rx_fifo_full_i;
   logic cc_over_200_i, cc_over_660_i, cc_over_1230_i, role_search_done_i, soft_reset_gave_up_i, resend_exhausted_i;
   logic hard_reset_out_i, packet_acked_i, soft_reset_in_i, hard_reset_in_i, auto_ack_sent_i, rx_sop_i, rx_crc_done_i;
   logic [9:0] ev = 10'h000; // Event pulses, bits 6:0 match event flag positions
   logic [2:0] flt = 3'h0; // Fault levels
   logic [5:0] lin = 6'h00; // Live level inputs
   logic [2:0] cmp = 3'h0; // Level comparators, thermometer coded
   logic [7:0] expq[$]; // Expected read data, oldest first
   logic [1:0] lv; // Random current level
   int num_errors = 0, checked = 0, n;
   assign {rx_sop_i, rx_crc_done_i, auto_ack_sent_i, role_search_done_i, soft_reset_gave_up_i} = ev[9:5];
   assign {resend_exhausted_i, hard_reset_out_i, packet_acked_i, soft_reset_in_i, hard_reset_in_i} = ev[4:0];
   assign {over_temp_i, vconn2_overcurrent_event_i, vconn1_overcurrent_event_i} = flt;
   assign {bus_power_present_i, cc_above_ref_i, wake_detect_i, wake_enable_i, tx_fifo_full_i, rx_fifo_full_i} = lin;
   assign {cc_over_1230_i, cc_over_660_i, cc_over_200_i} = cmp;
   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   pdis_top u_pdis_top (.*);
   pdis_partner u_pdis_partner (.mclk_i(mclk_i), .go_i(go), .edges_i(nedge), .cc_o(cc_line_i));
   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Read request; the expected answer is queued for the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      expq.push_back(e);
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
   endtask : rd
   task automatic pulse(input int i);
      @(posedge mclk_i);
      ev <= 10'(1 << i);
      @(posedge mclk_i);
      ev <= 10'h000;
   endtask : pulse
   task automatic idle(input int c);
      repeat (c) @(posedge mclk_i);
   endtask : idle
   task automatic burst(input logic [3:0] k);
      @(posedge mclk_i);
      nedge <= k;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
   endtask : burst
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   //------------------------------------------------------------
   // Read data monitor
   //------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (reg_rvalid_o === 1'b1) begin
         chk("read data", reg_rdata_o, expq.pop_front());
      end
   end
   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      void'($urandom(32'h9BF23A17));
      idle(16);
      resetn_i <= 1'b1;
      rd(ADDR_EVENT, RST_EVENT);
      rd(ADDR_ACK, RST_ACK);
      rd(ADDR_LIVE, RST_LIVE);
      rd(8'h41, 8'h00);
      for (n = 0; n < 7; n++) begin
         pulse(n);
         idle(1);
         chk("int low", {7'h00, int_n_o}, 8'h00);
         rd(ADDR_EVENT, 8'(1 << n));
         rd(ADDR_EVENT, 8'h00);
         idle(1);
         chk("int high", {7'h00, int_n_o}, 8'h01);
      end
      // Each fault source on its own raises the shared flag
      for (n = 0; n < 3; n++) begin
         flt <= 3'(1 << n);
         idle(5);
         rd(ADDR_EVENT, 8'h80);
         flt <= 3'h0;
         idle(4);
      end
      pulse(7);
      rd(ADDR_ACK, 8'h01);
      // Event lands on the same edge as the clearing read
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= ADDR_EVENT;
      ev <= 10'h010;
      expq.push_back(8'h00);
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      ev <= 10'h000;
      rd(ADDR_EVENT, 8'h10);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= ADDR_LIVE;
      reg_wdata_i <= 8'($urandom);
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      rd(ADDR_LIVE, 8'h00);
      // Two transitions are not yet activity, the third is
      burst(4'h2);
      idle(14);
      rd(ADDR_LIVE, 8'h00);
      burst(4'h1);
      idle(10);
      rd(ADDR_LIVE, 8'h40);
      idle(int'(ACT_QUIET_CYC) + 10);
      rd(ADDR_LIVE, 8'h00);
      lv = 2'($urandom);
      cmp <= 3'((4'h1 << lv) - 4'h1);
      lin <= 6'b111110;
      block_power_bits_i <= 4'h4;
      measure_first_cc_i <= 1'b1;
      idle(5);
      rd(ADDR_LIVE, {6'b101011, lv});
      lin <= 6'b011001;
      measure_first_cc_i <= 1'b0;
      measure_second_cc_i <= 1'b1;
      idle(5);
      rd(ADDR_LIVE, {6'b001010, lv});
      lin <= 6'h00;
      block_power_bits_i <= 4'hB;
      idle(5);
      rd(ADDR_LIVE, 8'h00);
      rx_sop_enabled_i <= 1'b1;
      rx_crc_ok_i <= 1'b1;
      pulse(8);
      rd(ADDR_LIVE, 8'h10);
      rx_crc_ok_i <= 1'b0;
      pulse(8);
      rd(ADDR_LIVE, 8'h00);
      // A good result is dropped again at the next packet start
      rx_crc_ok_i <= 1'b1;
      pulse(8);
      pulse(9);
      rd(ADDR_LIVE, 8'h00);
      // Bounded drain of outstanding reads
      for (n = 0; n < 20 && expq.size() != 0; n++) idle(1);
      if (expq.size() != 0) num_errors++;
      print_verdict();
   end
endmodule : pdis_top_test
